/* rwsc_params.svh */
// Constants for the reset, wake and strap control block.
// Overview of operation
// - While the hard reset pin is low every flip-flop of the block except the strap synchroniser sits in its reset state.
// - The hard reset pin is kept weakly pulled high, so an open pin leaves the power-on reset as the only reset source.
// - After power-up, reset or wake the host must read once before writing, and writes are ignored until that read.
// - With the wake indicator enabled, a detected wake event asserts the wake indicator to ask the system to wake.
// - Software picks the active polarity of the wake indicator and whether it drives push-pull or open-drain.
// - The wake indicator never wakes the device; only a host write with chip select and write strobe both low does.
// - Any host write wakes the device whatever its data, though the host is to aim it at the byte-order test register.
// - The speed-select strap is caught as reset releases, held, and sets the default speed and auto-negotiation; duplex is fixed at half.
`ifndef RWSC_PARAMS_SVH
`define RWSC_PARAMS_SVH
`define RWSC_CLK_PERIOD_PS 5000
`define RWSC_RESTART_NS 100
`define RWSC_RESTART_CYC ((`RWSC_RESTART_NS * 1000 + `RWSC_CLK_PERIOD_PS - 1) / `RWSC_CLK_PERIOD_PS)
`define RWSC_SYNC_RESET_VAL 1'b1
`define RWSC_STRAP_RESET_VAL 1'b0
`define RWSC_FULL_DUPLEX_DEFAULT 1'b0
`endif

/* rwsc_pkg.sv */
// Types for the reset, wake and strap control block.
package rwsc_pkg;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_WAKING
  } rwsc_pwr_t;
endpackage

/* rwsc_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`include "rwsc_params.svh"
module rwsc_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Stage one feeds stage two only, to keep metastability off the logic.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= `RWSC_SYNC_RESET_VAL;
      s2_r <= `RWSC_SYNC_RESET_VAL;
      s3_r <= `RWSC_SYNC_RESET_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // The output follows only when the last two stages agree.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout <= `RWSC_SYNC_RESET_VAL;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end
endmodule

/* rwsc_top.sv */
// Reset, wake and strap control: reset tree, wake detection and first-read gate.
`timescale 1ns/1ps
`include "rwsc_params.svh"
module rwsc_top
  import rwsc_pkg::*;
#(
  parameter int RESTART_CYC = `RWSC_RESTART_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hardResetInLow,
  output logic hardResetPullupEn,
  input wire logic chipSelectLow,
  input wire logic writeStrobeLow,
  input wire logic readStrobeLow,
  input wire logic sleepReq,
  input wire logic wakeEvent,
  input wire logic wakeClear,
  input wire logic wakeEnable,
  input wire logic wakeActiveHigh,
  input wire logic wakeOpenDrain,
  input wire logic speedSelIn,
  output logic wakeIndicatorOut,
  output logic wakeIndicatorOe,
  output logic coreRstLow,
  output logic coreClkEn,
  output logic awake,
  output logic writeAccept,
  output logic readSeen,
  output logic firstReadDone,
  output logic defaultSpeed100,
  output logic defaultFullDuplex,
  output logic defaultAutoNeg
);
  localparam int CW = $clog2(RESTART_CYC + 1);

  logic rstTree;
  logic rstMeta_r;
  logic rstDone_r;
  logic csLow;
  logic wrLow;
  logic rdLow;
  logic strapSync;
  logic wrCycle;
  logic wrCycleD_r;
  logic rdCycle;
  logic rdCycleD_r;
  logic wrStart;
  logic rdStart;
  logic strapTaken_r;
  logic wakeFlag_r;
  logic [CW-1:0] restartCnt_r;
  rwsc_pwr_t pwr_r;
  rwsc_pwr_t pwr_nxt;

  // The pad pull-up is always on, so an open pin reads high.
  assign hardResetPullupEn = 1'b1;

  // Either the power-on reset or the pin asserts the tree at once;
  // release is synchronous for the logic on rstDone_r; the strobe synchronisers are released by the tree directly.
  assign rstTree = nrst & hardResetInLow;

  // Two-stage reset release; assertion remains asynchronous.
  always_ff @(posedge clk or negedge rstTree) begin
    if (!rstTree) begin
      rstMeta_r <= 1'b0;
      rstDone_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstDone_r <= rstMeta_r;
    end
  end

  assign coreRstLow = rstDone_r;

  // Host strobes and strap come from pins and need synchronising.
  // They run on the free clock, never a gated one.
  rwsc_sync uCsSync (
    .clk(clk),
    .nrst(rstTree),
    .din(chipSelectLow),
    .dout(csLow)
  );
  rwsc_sync uWrSync (
    .clk(clk),
    .nrst(rstTree),
    .din(writeStrobeLow),
    .dout(wrLow)
  );
  rwsc_sync uRdSync (
    .clk(clk),
    .nrst(rstTree),
    .din(readStrobeLow),
    .dout(rdLow)
  );
  // The strap synchroniser is never reset, so it already tracks the pin
  // when either reset lets go; a reset value would be caught instead.
  rwsc_sync uStrapSync (
    .clk(clk),
    .nrst(1'b1),
    .din(speedSelIn),
    .dout(strapSync)
  );

  // A write needs chip select and write strobe both low; data is ignored.
  assign wrCycle = !csLow && !wrLow;
  assign rdCycle = !csLow && !rdLow;
  assign wrStart = wrCycle && !wrCycleD_r;
  assign rdStart = rdCycle && !rdCycleD_r;

  // Edge history of the qualified host cycles.
  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      wrCycleD_r <= 1'b0;
      rdCycleD_r <= 1'b0;
    end else begin
      wrCycleD_r <= wrCycle;
      rdCycleD_r <= rdCycle;
    end
  end

  // Power state: only a host write leaves sleep, never the wake flag.
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      PWR_RUN: begin
        if (sleepReq) begin
          pwr_nxt = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (wrStart) begin
          pwr_nxt = PWR_WAKING;
        end
      end
      PWR_WAKING: begin
        if (restartCnt_r == CW'(RESTART_CYC - 1)) begin
          pwr_nxt = PWR_RUN;
        end
      end
      // The spare code cannot be reached; fall back to running.
      default: begin
        pwr_nxt = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      pwr_r <= PWR_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Clock restart settling time after a wake write.
  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      restartCnt_r <= '0;
    end else if (pwr_r == PWR_WAKING) begin
      restartCnt_r <= restartCnt_r + CW'(1);
    end else begin
      restartCnt_r <= '0;
    end
  end

  // Gated clocks restart as soon as the wake write is seen.
  assign coreClkEn = (pwr_r != PWR_SLEEP);
  assign awake = (pwr_r == PWR_RUN);

  // First-read gate: cleared by reset and by every wake, set by a read.
  // A read that lands while waking still counts, since the host may not
  // know how long the clocks take to settle.
  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      firstReadDone <= 1'b0;
    end else if (pwr_r == PWR_SLEEP) begin
      firstReadDone <= 1'b0;
    end else if (rdStart) begin
      firstReadDone <= 1'b1;
    end
  end

  // Writes pass only when awake and after the first read; the wake
  // write itself is therefore always dropped.
  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      writeAccept <= 1'b0;
      readSeen <= 1'b0;
    end else begin
      writeAccept <= wrStart && firstReadDone && awake;
      readSeen <= rdStart && (pwr_r != PWR_SLEEP);
    end
  end

  // Sticky wake flag; a new event beats a clear in the same cycle.
  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      wakeFlag_r <= 1'b0;
    end else if (wakeEnable && wakeEvent) begin
      wakeFlag_r <= 1'b1;
    end else if (wakeClear || !wakeEnable) begin
      wakeFlag_r <= 1'b0;
    end
  end

  // Pin level follows polarity; open-drain only ever pulls low.
  always_comb begin
    wakeIndicatorOut = wakeFlag_r ~^ wakeActiveHigh;
    if (wakeOpenDrain) begin
      wakeIndicatorOe = !wakeIndicatorOut;
      wakeIndicatorOut = 1'b0;
    end else begin
      wakeIndicatorOe = 1'b1;
    end
  end

  // Strap is caught on the first edge after reset release and held.
  always_ff @(posedge clk or negedge rstDone_r) begin
    if (!rstDone_r) begin
      strapTaken_r <= 1'b0;
      defaultSpeed100 <= `RWSC_STRAP_RESET_VAL;
    end else if (!strapTaken_r) begin
      strapTaken_r <= 1'b1;
      defaultSpeed100 <= strapSync;
    end
  end

  // Strap one selects 100 Mb/s with auto-negotiation, always half duplex.
  assign defaultAutoNeg = defaultSpeed100;
  assign defaultFullDuplex = `RWSC_FULL_DUPLEX_DEFAULT;

  // Checks.
  a_reset_holds: assert property (@(posedge clk)
    !hardResetInLow |=> !coreRstLow && !firstReadDone && !wakeFlag_r)
    else $error("Core left reset while the reset pin was low.");

  a_write_gate: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    writeAccept |-> $past(firstReadDone) && $past(pwr_r) == PWR_RUN)
    else $error("Write accepted before the first read.");

  a_wake_clears: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    pwr_r == PWR_SLEEP |=> !firstReadDone)
    else $error("First-read gate not cleared in sleep.");

  a_wake_sets: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    wakeEnable && wakeEvent |=> wakeFlag_r)
    else $error("Wake event did not set the wake indicator.");

  a_pin_level: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    !wakeOpenDrain |-> wakeIndicatorOe &&
      wakeIndicatorOut == (wakeActiveHigh ? wakeFlag_r : !wakeFlag_r))
    else $error("Push-pull wake pin level wrong.");

  a_od_drive: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    wakeOpenDrain |-> !wakeIndicatorOut &&
      wakeIndicatorOe == (wakeFlag_r != wakeActiveHigh))
    else $error("Open-drain wake pin drive wrong.");

  a_sleep_hold: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    pwr_r == PWR_SLEEP && !wrStart |=> pwr_r == PWR_SLEEP)
    else $error("Left sleep without a host write.");

  a_wake_write: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    pwr_r == PWR_SLEEP && wrStart |=> coreClkEn ##0
      (pwr_r == PWR_WAKING)[*2])
    else $error("Wake write did not restart the clocks.");

  a_wake_done: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    $rose(pwr_r == PWR_WAKING) |-> ##[1:1000] pwr_r == PWR_RUN)
    else $error("Clock restart did not finish.");

  a_strap_hold: assert property (@(posedge clk)
    disable iff (!rstDone_r)
    strapTaken_r |=> $stable(defaultSpeed100) &&
      defaultAutoNeg == defaultSpeed100)
    else $error("Strap value changed after capture.");

  c_wake_cycle: cover property (@(posedge clk) disable iff (!rstDone_r)
    pwr_r == PWR_SLEEP ##1 pwr_r == PWR_WAKING);
  c_write_ok: cover property (@(posedge clk) disable iff (!rstDone_r)
    writeAccept);
  c_write_drop: cover property (@(posedge clk) disable iff (!rstDone_r)
    wrStart && !firstReadDone && awake);
  c_wake_flag: cover property (@(posedge clk) disable iff (!rstDone_r)
    $rose(wakeFlag_r));
endmodule

/* rwsc_host_model.sv */
// Behavioural model of the host processor that drives the strobe pins.
`timescale 1ns/1ps
module rwsc_host_model (
  input wire logic clk,
  output logic chipSelectLow,
  output logic writeStrobeLow,
  output logic readStrobeLow
);
  // All strobes start idle high, as a released host bus would sit.
  initial begin
    chipSelectLow = 1'b1;
    writeStrobeLow = 1'b1;
    readStrobeLow = 1'b1;
  end

  // One access: the strobes stay low for hold cycles, then idle for three.
  // Shorter strobes would be lost in the block's input synchronisers.
  task automatic access(input bit isWrite, input int hold);
    @(posedge clk);
    #1;
    chipSelectLow = 1'b0;
    if (isWrite) begin
      writeStrobeLow = 1'b0;
    end else begin
      readStrobeLow = 1'b0;
    end
    repeat (hold) @(posedge clk);
    #1;
    chipSelectLow = 1'b1;
    writeStrobeLow = 1'b1;
    readStrobeLow = 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* testbench.sv */
// Self-checking testbench for the reset, wake and strap control block.
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, hardResetInLow, chipSelectLow, writeStrobeLow;
  logic readStrobeLow, sleepReq, wakeEvent, wakeClear, wakeEnable;
  logic wakeActiveHigh, wakeOpenDrain, speedSelIn, hardResetPullupEn;
  logic wakeIndicatorOut, wakeIndicatorOe, coreRstLow, coreClkEn, awake;
  logic writeAccept, readSeen, firstReadDone, defaultSpeed100;
  logic defaultFullDuplex, defaultAutoNeg, s;
  int fail_count = 0;
  int total_checks = 0;
  int wrCnt = 0;
  int rdCnt = 0;
  int w;

  rwsc_top #(.RESTART_CYC(2)) i_dut (.clk, .nrst, .hardResetInLow,
    .hardResetPullupEn, .chipSelectLow, .writeStrobeLow, .readStrobeLow,
    .sleepReq, .wakeEvent, .wakeClear, .wakeEnable, .wakeActiveHigh,
    .wakeOpenDrain, .speedSelIn, .wakeIndicatorOut, .wakeIndicatorOe,
    .coreRstLow, .coreClkEn, .awake, .writeAccept, .readSeen,
    .firstReadDone, .defaultSpeed100, .defaultFullDuplex, .defaultAutoNeg);
  rwsc_host_model i_host (.clk, .chipSelectLow, .writeStrobeLow,
    .readStrobeLow);

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulses last one cycle, so they are counted on every edge.
  always @(posedge clk) begin
    if (writeAccept === 1'b1) wrCnt <= wrCnt + 1;
    if (readSeen === 1'b1) rdCnt <= rdCnt + 1;
  end

  task automatic chk_val(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Expected {data, enable} of the wake pin; open-drain only pulls low.
  function automatic logic [1:0] pin_exp(input logic on);
    logic lvl;
    lvl = wakeActiveHigh ? on : !on;
    return wakeOpenDrain ? {1'b0, !lvl} : {lvl, 1'b1};
  endfunction

  task automatic chk_pin(input logic on);
    chk_val({wakeIndicatorOut, wakeIndicatorOe}, pin_exp(on));
  endtask

  // Power-on reset with the strap held steady well before release.
  task automatic do_reset(input logic strap);
    @(posedge clk);
    #1;
    nrst = 1'b0;
    speedSelIn = strap;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    speedSelIn = !strap;
  endtask

  // Random strobe length keeps slow and prompt hosts both in play.
  task automatic acc(input bit isWrite);
    i_host.access(isWrite, 4 + $urandom_range(3));
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulse_event();
    @(posedge clk);
    #1;
    wakeEvent = 1'b1;
    @(posedge clk);
    #1;
    wakeEvent = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog sized far above the few hundred cycles the tests need.
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    {nrst, sleepReq, wakeEvent, wakeClear, wakeEnable} = 5'h00;
    {hardResetInLow, wakeActiveHigh, wakeOpenDrain, speedSelIn} = 4'h8;
    void'($urandom(32'h06CE));
    for (int i = 0; i < 3; i++) begin
      s = (i < 2) ? i[0] : 1'($urandom_range(1));
      do_reset(s);
      chk_val(defaultSpeed100, s);
      chk_val(defaultAutoNeg, s);
      chk_val(defaultFullDuplex, 1'b0);
      chk_val(hardResetPullupEn, 1'b1);
      chk_val(coreRstLow, 1'b1);
    end
    $display("strap test done");
    w = wrCnt;
    acc(1'b1);
    chk_cnt(wrCnt, w);
    acc(1'b0);
    chk_cnt(rdCnt, 1);
    chk_val(firstReadDone, 1'b1);
    acc(1'b1);
    acc(1'b1);
    chk_cnt(wrCnt, w + 2);
    $display("first read test done");
    for (int m = 0; m < 4; m++) begin
      {wakeOpenDrain, wakeActiveHigh} = 2'(m);
      wakeEnable = 1'b1;
      #5;
      chk_pin(1'b0);
      pulse_event();
      chk_pin(1'b1);
      wakeClear = 1'b1;
      @(posedge clk);
      #1;
      wakeClear = 1'b0;
      chk_pin(1'b0);
      // An event and a clear on the same edge must leave the flag set.
      {wakeEvent, wakeClear} = 2'h3;
      @(posedge clk);
      #1;
      {wakeEvent, wakeClear} = 2'h0;
      chk_pin(1'b1);
      wakeEnable = 1'b0;
      pulse_event();
      chk_pin(1'b0);
    end
    $display("wake pin test done");
    {wakeEnable, wakeActiveHigh, wakeOpenDrain} = 3'h6;
    sleepReq = 1'b1;
    @(posedge clk);
    #1;
    sleepReq = 1'b0;
    chk_val({coreClkEn, awake}, 2'h0);
    pulse_event();
    chk_pin(1'b1);
    acc(1'b0);
    chk_val({coreClkEn, awake}, 2'h0);
    w = wrCnt;
    acc(1'b1);
    chk_val({coreClkEn, awake}, 2'h3);
    chk_val(firstReadDone, 1'b0);
    acc(1'b1);
    chk_cnt(wrCnt, w);
    acc(1'b0);
    acc(1'b1);
    chk_cnt(wrCnt, w + 1);
    $display("sleep wake test done");
    hardResetInLow = 1'b0;
    @(posedge clk);
    #1;
    chk_val({coreRstLow, firstReadDone}, 2'h0);
    chk_pin(1'b0);
    hardResetInLow = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk_val(coreRstLow, 1'b1);
    chk_val(defaultSpeed100, speedSelIn);
    w = wrCnt;
    acc(1'b1);
    chk_cnt(wrCnt, w);
    $display("hard reset test done");
    close_out();
  end
endmodule
